// >>> hw/hardware_config_fuse_bank.sv
`timescale 1ns/1ps
// Function
// - Security bit clear blocks programming-mode flash access
// - Program lock blocks user writes, beats sector lock
// - Sector lock makes 4kB reset sector read-only to user writes
// - Bit 4 enables the 2kB boot ROM
// - Bit 3 lets watchdog timeout reset device
// - Bits 2-0 select data flash partition size
// - Bits 7-6 select digital brownout trip level
// - Bits 5-4 select analog brownout level, same code
// - Bit 3 high disables analog brownout reset
// - Bit 2 high disables digital brownout reset
// - Bit 1 low: port 0 external bus
// - Bit 0 low: port 2 external bus
// - Byte 7Eh writable only programming, readable always
// - Config changes only in serial/parallel programming; mass_erase here clears both bytes in any mode
// - Byte 7Fh read via address then data register
module hardware_config_fuse_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic serial_prog_mode,
  input wire logic parallel_prog_mode,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic mass_erase,
  input wire logic flash_wr_req,
  input wire logic [15:0] flash_wr_addr,
  output logic flash_wr_grant,
  output logic prog_flash_access_ok,
  output logic boot_rom_enable,
  output logic watchdog_reset_enable,
  input wire logic wdt_timeout,
  output logic wdt_reset,
  output hw_config_pkg::data_flash_size_t data_flash_size_sel,
  output hw_config_pkg::brownout_level_t digital_brownout_level,
  output hw_config_pkg::brownout_level_t analog_brownout_level,
  output logic analog_brownout_reset_off,
  output logic digital_brownout_reset_off,
  input wire logic dvdd_low,
  input wire logic avdd_low,
  output logic brownout_reset,
  output logic port_zero_gpio_sel,
  output logic port_two_three_gpio_sel,
  output logic ext_strobes_on_p3
);
  import hw_config_pkg::*;

  function automatic logic is_cfg_addr(input logic [7:0] a);
    is_cfg_addr = (a == SUPPLY_CFG_ADDR) || (a == SECURITY_CFG_ADDR);
  endfunction

  logic [7:0] supply_nv;
  logic [7:0] security_nv;
  logic user_application_mode;
  logic nv_wr;

  load_state_t state_reg, state_next;
  logic [7:0] security_and_memory_config_reg, security_and_memory_config_next;
  logic [7:0] supply_and_port_config_reg, supply_and_port_config_next;
  logic [7:0] config_address_reg, config_address_next;
  logic [7:0] rdata_reg, rdata_next;
  logic erased_reg, erased_next;
  logic grant_reg, grant_next;
  logic wdt_rst_reg, wdt_rst_next;
  logic bo_rst_reg, bo_rst_next;
  logic access_ok_reg, access_ok_next;
  logic strobes_reg, strobes_next;

  assign user_application_mode = !(serial_prog_mode || parallel_prog_mode);
  // Storage accepts a byte only from the programming modes
  assign nv_wr = sfr_wr && (sfr_addr == CFG_DATA_SFR) && !user_application_mode
                 && is_cfg_addr(config_address_reg);

  config_nv_store u_store (
    .clk_sys(clk_sys),
    .por_n(por_n),
    .wr_en(nv_wr),
    .wr_sel_security(config_address_reg == SECURITY_CFG_ADDR),
    .wr_data(sfr_wdata),
    .mass_erase(mass_erase),
    .supply_byte(supply_nv),
    .security_byte(security_nv)
  );

  always_comb begin
    state_next = state_reg;
    security_and_memory_config_next = security_and_memory_config_reg;
    supply_and_port_config_next = supply_and_port_config_reg;
    case (state_reg)
      ST_LOAD: begin
        // One copy per reset; later storage writes wait for the next reset
        security_and_memory_config_next = security_nv;
        supply_and_port_config_next = supply_nv;
        state_next = ST_RUN;
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_LOAD;
    endcase
    // Strobe select kept in its own flop so the pin comes straight from a register
    strobes_next = !(supply_and_port_config_next[P0_GPIO_BIT]
                     && supply_and_port_config_next[P23_GPIO_BIT]);
  end

  always_comb begin
    config_address_next = config_address_reg;
    rdata_next = rdata_reg;
    if (sfr_wr && (sfr_addr == CFG_ADDR_SFR)) begin
      config_address_next = sfr_wdata;
    end
    if (sfr_rd) begin
      case (sfr_addr)
        CFG_ADDR_SFR: rdata_next = config_address_reg;
        CFG_DATA_SFR: begin
          if (config_address_reg == SECURITY_CFG_ADDR) begin
            rdata_next = security_nv;
          end else if (config_address_reg == SUPPLY_CFG_ADDR) begin
            rdata_next = supply_nv;
          end else begin
            rdata_next = SFR_RESET_VALUE;
          end
        end
        default: rdata_next = SFR_RESET_VALUE;
      endcase
    end
  end

  always_comb begin
    logic in_reset_sector;
    in_reset_sector = flash_wr_addr < RESET_SECTOR_END;
    // Mass erase lifts the security restriction until the next reset
    erased_next = erased_reg || mass_erase;
    access_ok_next = security_and_memory_config_next[SEC_OPEN_BIT] || erased_next;
    grant_next = 1'b0;
    if (flash_wr_req && (state_reg == ST_RUN)) begin
      if (user_application_mode) begin
        if (security_and_memory_config_reg[PROG_LOCK_BIT]) begin
          grant_next = 1'b0;
        end else begin
          grant_next = !(in_reset_sector
                         && security_and_memory_config_reg[RST_LOCK_BIT]);
        end
      end else begin
        grant_next = security_and_memory_config_reg[SEC_OPEN_BIT] || erased_reg;
      end
    end
    wdt_rst_next = wdt_timeout && security_and_memory_config_reg[WDT_RST_BIT];
    bo_rst_next = (dvdd_low && !supply_and_port_config_reg[DBO_OFF_BIT])
                  || (avdd_low && !supply_and_port_config_reg[ABO_OFF_BIT]);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_LOAD;
      security_and_memory_config_reg <= CFG_ERASED_VALUE;
      supply_and_port_config_reg <= CFG_ERASED_VALUE;
      strobes_reg <= !(CFG_ERASED_VALUE[P0_GPIO_BIT] && CFG_ERASED_VALUE[P23_GPIO_BIT]);
    end else begin
      state_reg <= state_next;
      security_and_memory_config_reg <= security_and_memory_config_next;
      supply_and_port_config_reg <= supply_and_port_config_next;
      strobes_reg <= strobes_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      config_address_reg <= SFR_RESET_VALUE;
      rdata_reg <= SFR_RESET_VALUE;
    end else begin
      config_address_reg <= config_address_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      erased_reg <= 1'b0;
      grant_reg <= 1'b0;
      wdt_rst_reg <= 1'b0;
      bo_rst_reg <= 1'b0;
      access_ok_reg <= CFG_ERASED_VALUE[SEC_OPEN_BIT];
    end else begin
      erased_reg <= erased_next;
      grant_reg <= grant_next;
      wdt_rst_reg <= wdt_rst_next;
      bo_rst_reg <= bo_rst_next;
      access_ok_reg <= access_ok_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign flash_wr_grant = grant_reg;
  assign prog_flash_access_ok = access_ok_reg;
  assign boot_rom_enable = security_and_memory_config_reg[BOOT_ROM_BIT];
  assign watchdog_reset_enable = security_and_memory_config_reg[WDT_RST_BIT];
  assign wdt_reset = wdt_rst_reg;
  assign data_flash_size_sel =
    data_flash_size_t'(security_and_memory_config_reg[DFSIZE_MSB:DFSIZE_LSB]);
  assign digital_brownout_level =
    brownout_level_t'(supply_and_port_config_reg[DBL_MSB:DBL_LSB]);
  assign analog_brownout_level =
    brownout_level_t'(supply_and_port_config_reg[ABL_MSB:ABL_LSB]);
  assign analog_brownout_reset_off = supply_and_port_config_reg[ABO_OFF_BIT];
  assign digital_brownout_reset_off = supply_and_port_config_reg[DBO_OFF_BIT];
  assign brownout_reset = bo_rst_reg;
  assign port_zero_gpio_sel = supply_and_port_config_reg[P0_GPIO_BIT];
  assign port_two_three_gpio_sel = supply_and_port_config_reg[P23_GPIO_BIT];
  assign ext_strobes_on_p3 = strobes_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_user_cfg_write: assert property (
    user_application_mode && !mass_erase |=> $stable(supply_nv) && $stable(security_nv))
    else $error("config storage written outside programming mode");
  a_prog_lock_wins: assert property (
    flash_wr_req && user_application_mode && security_and_memory_config_reg[PROG_LOCK_BIT]
    |=> !flash_wr_grant)
    else $error("user write granted under program lock");
  a_sector_lock: assert property (
    flash_wr_req && user_application_mode && (state_reg == ST_RUN)
    && !security_and_memory_config_reg[PROG_LOCK_BIT]
    |=> flash_wr_grant == !($past(flash_wr_addr) < RESET_SECTOR_END
                            && security_and_memory_config_reg[RST_LOCK_BIT]))
    else $error("reset sector lock not applied");
  a_security_gate: assert property (
    flash_wr_req && !user_application_mode && (state_reg == ST_RUN)
    |=> flash_wr_grant == $past(prog_flash_access_ok))
    else $error("programming-mode access ignores security");
  a_wdt_gate: assert property (wdt_timeout ##1 wdt_reset |-> watchdog_reset_enable)
    else $error("watchdog reset while disabled");
  a_brownout_gate: assert property (
    !dvdd_low && !avdd_low ##1 brownout_reset |-> 1'b0)
    else $error("brownout reset without low supply");
  a_latch_hold: assert property (
    state_reg == ST_RUN |=> $stable(security_and_memory_config_reg)
                            && $stable(supply_and_port_config_reg))
    else $error("config latches changed before reset");
  a_load_once: assert property (
    $rose(state_reg == ST_RUN) |-> security_and_memory_config_reg == $past(security_nv))
    else $error("config latch not loaded from storage");
  a_data_read: assert property (
    sfr_rd && sfr_addr == CFG_DATA_SFR && config_address_reg == SECURITY_CFG_ADDR
    |=> sfr_rdata == $past(security_nv))
    else $error("indirect read of byte 7Fh wrong");

  c_prog_write: cover property (serial_prog_mode && nv_wr);
  c_user_grant: cover property (flash_wr_req && user_application_mode ##1 flash_wr_grant);
  c_erase_open: cover property (mass_erase ##1 prog_flash_access_ok);
endmodule // hardware_config_fuse_bank

// >>> hw/hw_config_pkg.sv
package hw_config_pkg;
  localparam logic [7:0] CFG_ADDR_SFR = 8'h93;
  localparam logic [7:0] CFG_DATA_SFR = 8'h94;
  localparam logic [7:0] SUPPLY_CFG_ADDR = 8'h7E;
  localparam logic [7:0] SECURITY_CFG_ADDR = 8'h7F;
  localparam logic [7:0] SFR_RESET_VALUE = 8'h00;
  localparam logic [7:0] CFG_ERASED_VALUE = 8'hFF;
  // Fields of security_and_memory_config
  localparam int SEC_OPEN_BIT = 7;
  localparam int PROG_LOCK_BIT = 6;
  localparam int RST_LOCK_BIT = 5;
  localparam int BOOT_ROM_BIT = 4;
  localparam int WDT_RST_BIT = 3;
  localparam int DFSIZE_MSB = 2;
  localparam int DFSIZE_LSB = 0;
  // Fields of supply_and_port_config
  localparam int DBL_MSB = 7;
  localparam int DBL_LSB = 6;
  localparam int ABL_MSB = 5;
  localparam int ABL_LSB = 4;
  localparam int ABO_OFF_BIT = 3;
  localparam int DBO_OFF_BIT = 2;
  localparam int P0_GPIO_BIT = 1;
  localparam int P23_GPIO_BIT = 0;
  // Reset sector occupies the lowest 4kB of program flash
  localparam logic [15:0] RESET_SECTOR_END = 16'h1000;
  typedef enum logic [1:0] {
    BO_4V5 = 2'b00,
    BO_4V2 = 2'b01,
    BO_2V7 = 2'b10,
    BO_2V5 = 2'b11
  } brownout_level_t;
  typedef enum logic [2:0] {
    DF_RESERVED = 3'b000,
    DF_UPTO_32K = 3'b001,
    DF_UPTO_16K = 3'b010,
    DF_UPTO_8K = 3'b011,
    DF_4K = 3'b100,
    DF_2K = 3'b101,
    DF_1K = 3'b110,
    DF_NONE = 3'b111
  } data_flash_size_t;
  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } load_state_t;
endpackage

// >>> hw/config_nv_store.sv
`timescale 1ns/1ps
module config_nv_store (
  input wire logic clk_sys,
  input wire logic por_n,
  input wire logic wr_en,
  input wire logic wr_sel_security,
  input wire logic [7:0] wr_data,
  input wire logic mass_erase,
  output logic [7:0] supply_byte,
  output logic [7:0] security_byte
);
  import hw_config_pkg::*;
  logic [7:0] cell_reg [2];
  logic [7:0] cell_next [2];

  // Index 0 holds the byte at 7Eh, index 1 the byte at 7Fh
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cell
      always_comb begin
        cell_next[gi] = cell_reg[gi];
        if (mass_erase) begin
          cell_next[gi] = CFG_ERASED_VALUE;
        end else if (wr_en && (wr_sel_security == gi[0])) begin
          cell_next[gi] = wr_data;
        end
      end
      // Only power-up and mass erase clear the cells; system reset leaves them alone
      always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
          cell_reg[gi] <= CFG_ERASED_VALUE;
        end else begin
          cell_reg[gi] <= cell_next[gi];
        end
      end
    end
  endgenerate

  assign supply_byte = cell_reg[0];
  assign security_byte = cell_reg[1];
endmodule // config_nv_store

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import hw_config_pkg::*;
  logic clk_sys, rst_n, por_n, serial_prog_mode, parallel_prog_mode, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
  logic mass_erase, flash_wr_req, wdt_timeout, dvdd_low, avdd_low, seen;
  logic [15:0] flash_wr_addr;
  logic flash_wr_grant, prog_flash_access_ok, boot_rom_enable, watchdog_reset_enable, wdt_reset;
  data_flash_size_t data_flash_size_sel;
  brownout_level_t digital_brownout_level, analog_brownout_level;
  logic analog_brownout_reset_off, digital_brownout_reset_off, brownout_reset;
  logic port_zero_gpio_sel, port_two_three_gpio_sel, ext_strobes_on_p3;
  int miscompares, samples_checked;

  hardware_config_fuse_bank dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n), .serial_prog_mode(serial_prog_mode),
    .parallel_prog_mode(parallel_prog_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mass_erase(mass_erase),
    .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr),
    .flash_wr_grant(flash_wr_grant), .prog_flash_access_ok(prog_flash_access_ok),
    .boot_rom_enable(boot_rom_enable), .watchdog_reset_enable(watchdog_reset_enable),
    .wdt_timeout(wdt_timeout), .wdt_reset(wdt_reset), .data_flash_size_sel(data_flash_size_sel),
    .digital_brownout_level(digital_brownout_level),
    .analog_brownout_level(analog_brownout_level),
    .analog_brownout_reset_off(analog_brownout_reset_off),
    .digital_brownout_reset_off(digital_brownout_reset_off), .dvdd_low(dvdd_low),
    .avdd_low(avdd_low), .brownout_reset(brownout_reset),
    .port_zero_gpio_sel(port_zero_gpio_sel), .port_two_three_gpio_sel(port_two_three_gpio_sel),
    .ext_strobes_on_p3(ext_strobes_on_p3)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_mode(input logic s, input logic p);
    @(posedge clk_sys);
    serial_prog_mode <= s;
    parallel_prog_mode <= p;
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    #1 d = sfr_rdata;
  endtask

  task automatic cfg_read(input logic [7:0] ca, output logic [7:0] d);
    sfr_write(CFG_ADDR_SFR, ca);
    sfr_read(CFG_DATA_SFR, d);
  endtask

  // One-cycle request on a chosen input; seen is the answer over the next two cycles
  task automatic pulse(input int which, input logic [15:0] a, output logic got);
    @(posedge clk_sys);
    flash_wr_addr <= a;
    flash_wr_req <= (which == 0);
    wdt_timeout <= (which == 1);
    dvdd_low <= (which == 2);
    avdd_low <= (which == 3);
    @(posedge clk_sys);
    {flash_wr_req, wdt_timeout, dvdd_low, avdd_low} <= 4'h0;
    #1 got = (which == 0) ? flash_wr_grant : (which == 1) ? wdt_reset : brownout_reset;
    @(posedge clk_sys);
    #1 got = got | ((which == 0) ? flash_wr_grant : (which == 1) ? wdt_reset : brownout_reset);
  endtask

  function automatic logic [15:0] outs();
    return {1'b0, boot_rom_enable, watchdog_reset_enable, data_flash_size_sel,
      digital_brownout_level, analog_brownout_level, analog_brownout_reset_off,
      digital_brownout_reset_off, port_zero_gpio_sel, port_two_three_gpio_sel,
      ext_strobes_on_p3, prog_flash_access_ok};
  endfunction

  localparam logic [15:0] DEFAULT_OUTS = {1'b0, 1'b1, 1'b1, DF_NONE, BO_2V5, BO_2V5,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  localparam logic [15:0] NEW_OUTS = {1'b0, 1'b0, 1'b0, DF_UPTO_16K, BO_2V7, BO_4V2,
    1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  task automatic t_defaults();
    check(outs(), DEFAULT_OUTS);
    cfg_read(SECURITY_CFG_ADDR, rd);
    check(rd, 16'h00FF);
    sfr_write(CFG_ADDR_SFR, SUPPLY_CFG_ADDR);
    sfr_write(CFG_DATA_SFR, 8'h00);
    sfr_read(CFG_DATA_SFR, rd);
    check(rd, 16'h00FF);
    sfr_read(8'h95, rd);
    check(rd, 16'h0000);
    pulse(0, 16'h2000, seen);
    check(seen, 1'b0);
    pulse(1, 16'h0000, seen);
    check(seen, 1'b1);
    pulse(2, 16'h0000, seen);
    check(seen, 1'b0);
    pulse(3, 16'h0000, seen);
    check(seen, 1'b0);
    set_mode(1'b1, 1'b0);
    pulse(0, 16'h2000, seen);
    check(seen, 1'b1);
  endtask

  task automatic t_program();
    sfr_write(CFG_ADDR_SFR, SECURITY_CFG_ADDR);
    sfr_write(CFG_DATA_SFR, 8'h22);
    set_mode(1'b0, 1'b1);
    cfg_read(SUPPLY_CFG_ADDR, rd);
    sfr_write(CFG_DATA_SFR, 8'h96);
    sfr_read(CFG_DATA_SFR, rd);
    check(rd, 16'h0096);
    cfg_read(SECURITY_CFG_ADDR, rd);
    check(rd, 16'h0022);
    check(outs(), DEFAULT_OUTS);
    set_mode(1'b0, 1'b0);
    do_reset();
    check(outs(), NEW_OUTS);
  endtask

  task automatic t_locks();
    pulse(0, 16'h0FFF, seen);
    check(seen, 1'b0);
    pulse(0, RESET_SECTOR_END, seen);
    check(seen, 1'b1);
    pulse(1, 16'h0000, seen);
    check(seen, 1'b0);
    pulse(2, 16'h0000, seen);
    check(seen, 1'b0);
    pulse(3, 16'h0000, seen);
    check(seen, 1'b1);
    set_mode(1'b1, 1'b0);
    pulse(0, 16'h2000, seen);
    check(seen, 1'b0);
    @(posedge clk_sys);
    mass_erase <= 1'b1;
    @(posedge clk_sys);
    mass_erase <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check(prog_flash_access_ok, 1'b1);
    pulse(0, 16'h2000, seen);
    check(seen, 1'b1);
    cfg_read(SECURITY_CFG_ADDR, rd);
    check(rd, 16'h00FF);
    sfr_read(CFG_ADDR_SFR, rd);
    check(rd, 16'h007F);
  endtask

  initial begin
    {serial_prog_mode, parallel_prog_mode, sfr_wr, sfr_rd, mass_erase} = 5'h00;
    {flash_wr_req, wdt_timeout, dvdd_low, avdd_low} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    flash_wr_addr = 16'h0000;
    miscompares = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    por_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    por_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_defaults();
    set_mode(1'b1, 1'b0);
    t_program();
    t_locks();
    complete_run();
  end

  initial begin
    #(3000 * 100);
    miscompares++;
    complete_run();
  end
endmodule // tb
